// ### design/reset_control_unit.sv
// Reset control unit: reset merge, warm-up sequencing, commit registers and cause flags
// What this block does
// - External and all internal-factor resets merge into one system reset.
// - Committed RAM-map bit maps RAM into code space 0x0040 to 0x083F.
// - Committed relocation bit moves vector-call and interrupt tables to low addresses.
// - Staged reset-disable bit acts only after commit code 0xb2.
// - Key decodes 0xb2, 0xd4, 0x71; any other value is ignored.
// - Committed disable cleared by power-on only; staging cleared by every reset.
// - Status shows committed bits 2..0; upper bits of status and staging read zero.
// - Cause register holds one flag per internal reset source; bit 7 reads zero.
// - Bit 5 reads one when loaded trimming data was abnormal.
// - Cause flags clear only on power-on, external reset or committed clear.
// - Clear bit plus code 0x71 clears all flags and the clear bit.
// - While any reset is asserted, warm-up counter, CPU and peripherals stay reset.
// - After release warm-up counts clock cycles, then stops; CPU waits for it.
// - Trimming data is loaded from flash into latches during warm-up.
// - After warm-up the CPU fetches its reset vector from 0xfffe to 0xffff.
// - A reset during warm-up restarts the count after the new release.
// - PC, SP and interrupt state are held at reset values through warm-up.
// - Reset keeps high oscillator on, low oscillator off, prescaler cleared.
// - Watchdog off and ports high-impedance until warm-up ends.
// - Only power-on or external reset disables voltage detection.
// - Power-on and external reset are ORed; release needs both released.
// - Committed disable one makes the pin open-drain I/O, zero a reset input.
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
module reset_control_unit
    import rcu_pkg::*;
#(
    parameter int WARMUP = WARMUP_CYCLES,
    parameter int TRIM_N = TRIM_WORDS
) (
    // Clock, bus reset and clock enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [11:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Reset sources (asynchronous levels)
    input wire logic por_i,
    input wire logic ext_pin_i,
    input wire rcu_pkg::int_reset_t int_rst_i,
    // Shared reset pin as open-drain port
    input wire logic pin_drive_low_i,
    output logic pin_o,
    output logic pin_oe_o,
    output logic pin_port_o,
    // Trim flash port
    output logic [7:0] trim_addr_o,
    input wire logic [8:0] trim_data_i,
    output logic [8*TRIM_N-1:0] trim_latch_o,
    // Chip controls
    output rcu_pkg::chip_ctrl_t ctrl_o,
    output rcu_pkg::commit_t commit_o,
    output logic lvd_disable_o,
    output logic [15:0] pc_o,
    output logic [15:0] sp_o,
    // Address map results
    input wire logic [15:0] code_addr_i,
    output logic ram_hit_o,
    output logic [15:0] vcall_base_o,
    output logic [15:0] ivec_base_o
);
    import rcu_pkg::*;

    // =======================================
    // Input synchronisation
    logic por_s, pin_s;
    int_reset_t irq_s;
    logic [7:0] cause_nxt;

    rcu_sync #(.WIDTH(8)) u_sync (
        .clk_i(clk_i),
        .ce_i(ce_i),
        .d_i({por_i, ext_pin_i, int_rst_i}),
        .q_o({por_s, pin_s, irq_s})
    );

    // =======================================
    // Reset merge
    logic ext_rst, int_rst, any_rst, hard_rst;
    // One flop per committed bit; disable resets on power-on, both mapping bits on any reset
    logic dis_r, ram_r, vec_r;
    assign commit_o = '{vector_relocate_state: vec_r, ram_code_map_state: ram_r, ext_reset_disable_state: dis_r};
    assign ext_rst = !commit_o.ext_reset_disable_state && !pin_s;
    assign hard_rst = por_s || ext_rst;
    assign int_rst = |irq_s;
    assign any_rst = hard_rst || int_rst;

    // =======================================
    // Bus decode
    logic req, wr, key_wr, stage_wr, cause_wr;
    logic [7:0] wbyte;
    assign req = cyc_i && stb_i && !ack_o;
    assign wr = req && we_i && sel_i[0];
    assign wbyte = dat_i[7:0];
    assign key_wr = wr && adr_i == OFF_KEY;
    assign stage_wr = wr && adr_i == OFF_STAGE;
    assign cause_wr = wr && adr_i == OFF_CAUSE;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else if (ce_i) begin
            ack_o <= req;
        end
    end

    // =======================================
    // Staging register, cleared by any reset
    logic [2:0] stage_r;
    logic fclr_r;
    always_ff @(posedge clk_i) begin
        if (rst_i || any_rst) begin
            stage_r <= 3'b000;
        end else if (ce_i && stage_wr) begin
            stage_r <= wbyte[2:0];
        end
    end

    // Clear request: committed clear wins its own cycle and then drops
    always_ff @(posedge clk_i) begin
        if (rst_i || hard_rst) begin
            fclr_r <= 1'b0;
        end else if (ce_i) begin
            if (key_wr && wbyte == KEY_FCLR && fclr_r) begin
                fclr_r <= 1'b0;
            end else if (cause_wr) begin
                fclr_r <= wbyte[BIT_FCLR];
            end
        end
    end

    // =======================================
    // Commit logic
    always_ff @(posedge clk_i) begin
        if (rst_i || por_s) begin
            dis_r <= 1'b0;
        end else if (ce_i && key_wr && wbyte == KEY_RSTDIS) begin
            dis_r <= stage_r[BIT_DIS];
        end
    end

    // Mapping bits are plain control state and follow every reset like the staging copy
    always_ff @(posedge clk_i) begin
        if (rst_i || any_rst) begin
            ram_r <= 1'b0;
            vec_r <= 1'b0;
        end else if (ce_i && key_wr && wbyte == KEY_MAP) begin
            ram_r <= stage_r[BIT_RAM];
            vec_r <= stage_r[BIT_VEC];
        end
    end

    // =======================================
    // Warm-up sequencer
    seq_state_t state_r;
    logic [31:0] wu_cnt_r;
    logic trim_done, trim_bad;

    always_ff @(posedge clk_i) begin
        if (rst_i || any_rst) begin
            state_r <= ST_RESET;
            wu_cnt_r <= 32'h0;
        end else if (ce_i) begin
            case (state_r)
                ST_RESET: begin
                    state_r <= ST_WARMUP;
                    wu_cnt_r <= 32'h0;
                end
                ST_WARMUP: begin
                    // Count never ends before the trim load has finished
                    if (wu_cnt_r >= 32'(WARMUP - 1) && trim_done) begin
                        state_r <= ST_RUN;
                    end else if (wu_cnt_r < 32'(WARMUP - 1)) begin
                        wu_cnt_r <= wu_cnt_r + 32'h1;
                    end
                end
                default: begin
                    state_r <= ST_RUN;
                end
            endcase
        end
    end

    rcu_trim_loader #(.WORDS(TRIM_N)) u_trim (
        .clk_i(clk_i),
        .ce_i(ce_i),
        .clear_i(rst_i || any_rst),
        .start_i(state_r == ST_WARMUP),
        .addr_o(trim_addr_o),
        .data_i(trim_data_i),
        .trim_o(trim_latch_o),
        .done_o(trim_done),
        .bad_o(trim_bad)
    );

    // =======================================
    // Cause flags
    logic [7:0] cause_r;
    always_comb begin
        cause_nxt = cause_r;
        if (fclr_r && key_wr && wbyte == KEY_FCLR) begin
            cause_nxt = 8'h00;
        end
        // A fresh event wins over a clear in the same cycle
        cause_nxt[BIT_WDT] = cause_nxt[BIT_WDT] | irq_s.watchdog;
        cause_nxt[BIT_SYS] = cause_nxt[BIT_SYS] | irq_s.sysclk;
        cause_nxt[BIT_LV1] = cause_nxt[BIT_LV1] | irq_s.low_volt1;
        cause_nxt[BIT_LV2] = cause_nxt[BIT_LV2] | irq_s.low_volt2;
        cause_nxt[BIT_TRF] = cause_nxt[BIT_TRF] | irq_s.trim;
        cause_nxt[BIT_FLS] = cause_nxt[BIT_FLS] | irq_s.flash_standby;
        if (state_r == ST_WARMUP && trim_done && trim_bad) begin
            cause_nxt[BIT_TDS] = 1'b1;
        end
        cause_nxt[7] = 1'b0;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || hard_rst) begin
            cause_r <= RST_BYTE;
        end else if (ce_i) begin
            cause_r <= cause_nxt;
        end
    end

    // =======================================
    // Read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0;
        end else if (ce_i && req) begin
            if (adr_i == OFF_CAUSE) begin
                dat_o <= {24'h0, cause_r};
            end else if (adr_i == OFF_STAGE) begin
                dat_o <= {29'h0, stage_r};
            end else if (adr_i == OFF_KEY) begin
                dat_o <= {29'h0, commit_o};
            end else begin
                dat_o <= 32'h0;
            end
        end
    end

    // =======================================
    // Chip controls and core reset state
    logic running;
    assign running = state_r == ST_RUN;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_o <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
            pc_o <= PC_RESET;
            sp_o <= SP_RESET;
            lvd_disable_o <= 1'b1;
        end else if (ce_i) begin
            ctrl_o.sys_reset <= !running;
            ctrl_o.warmup_active <= state_r == ST_WARMUP;
            ctrl_o.hf_osc_en <= 1'b1;
            ctrl_o.lf_osc_en <= running && ctrl_o.lf_osc_en;
            ctrl_o.prescaler_clr <= !running;
            ctrl_o.watchdog_en <= running;
            ctrl_o.port_hiz <= !running;
            ctrl_o.intr_clear <= !running;
            // PC and SP hold reset values until the core takes over at the vector
            pc_o <= PC_RESET;
            sp_o <= SP_RESET;
            if (hard_rst) begin
                lvd_disable_o <= 1'b1;
            end else if (running) begin
                lvd_disable_o <= 1'b0;
            end
        end
    end

    // =======================================
    // Shared pin and address map
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_o <= 1'b0;
            pin_oe_o <= 1'b0;
            pin_port_o <= 1'b0;
            ram_hit_o <= 1'b0;
            vcall_base_o <= VCALL_BASE_0;
            ivec_base_o <= IVEC_BASE_0;
        end else if (ce_i) begin
            pin_o <= 1'b0;
            pin_oe_o <= commit_o.ext_reset_disable_state && pin_drive_low_i && running;
            pin_port_o <= commit_o.ext_reset_disable_state && pin_s;
            ram_hit_o <= commit_o.ram_code_map_state && code_addr_i >= RAM_MAP_LO
                && code_addr_i <= RAM_MAP_HI;
            vcall_base_o <= commit_o.vector_relocate_state ? VCALL_BASE_1 : VCALL_BASE_0;
            ivec_base_o <= commit_o.vector_relocate_state ? IVEC_BASE_1 : IVEC_BASE_0;
        end
    end
endmodule // reset_control_unit

// ### design/rcu_pkg.sv
// Package with register map, field positions, reset values, codes and states of the reset control unit
package rcu_pkg;

    // =======================================
    // Register offsets (byte addresses)
    localparam logic [11:0] OFF_CAUSE = 12'hfcc;
    localparam logic [11:0] OFF_STAGE = 12'hfde;
    localparam logic [11:0] OFF_KEY = 12'hfdf;

    // =======================================
    // Commit codes
    localparam logic [7:0] KEY_RSTDIS = 8'hb2;
    localparam logic [7:0] KEY_MAP = 8'hd4;
    localparam logic [7:0] KEY_FCLR = 8'h71;

    // =======================================
    // Field positions
    localparam int BIT_DIS = 0;
    localparam int BIT_RAM = 1;
    localparam int BIT_VEC = 2;
    localparam int BIT_WDT = 0;
    localparam int BIT_SYS = 1;
    localparam int BIT_LV1 = 2;
    localparam int BIT_LV2 = 3;
    localparam int BIT_TRF = 4;
    localparam int BIT_TDS = 5;
    localparam int BIT_FLS = 6;
    localparam int BIT_FCLR = 7;

    // =======================================
    // Reset values and fixed addresses
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] PC_RESET = 16'hfffe;
    localparam logic [15:0] SP_RESET = 16'h00ff;
    localparam logic [15:0] RAM_MAP_LO = 16'h0040;
    localparam logic [15:0] RAM_MAP_HI = 16'h083f;
    localparam logic [15:0] VCALL_BASE_0 = 16'hffa0;
    localparam logic [15:0] VCALL_BASE_1 = 16'h01a0;
    localparam logic [15:0] IVEC_BASE_0 = 16'hffc2;
    localparam logic [15:0] IVEC_BASE_1 = 16'h01c2;
    localparam int WARMUP_CYCLES = 1024;
    localparam int TRIM_WORDS = 4;

    // =======================================
    // Types
    typedef enum logic [1:0] {
        ST_RESET,
        ST_WARMUP,
        ST_RUN
    } seq_state_t;

    // Internal factor reset requests, one bit per source
    typedef struct packed {
        logic flash_standby;
        logic trim;
        logic low_volt2;
        logic low_volt1;
        logic sysclk;
        logic watchdog;
    } int_reset_t;

    // Chip-wide reset controls
    typedef struct packed {
        logic sys_reset;
        logic warmup_active;
        logic hf_osc_en;
        logic lf_osc_en;
        logic prescaler_clr;
        logic watchdog_en;
        logic port_hiz;
        logic intr_clear;
    } chip_ctrl_t;

    // Committed mapping and reset-disable state
    typedef struct packed {
        logic vector_relocate_state;
        logic ram_code_map_state;
        logic ext_reset_disable_state;
    } commit_t;

endpackage

// ### design/rcu_sync.sv
// Two-flop synchroniser for asynchronous reset request levels
`timescale 1ns/1ps
module rcu_sync #(
    parameter int WIDTH = 1
) (
    // Clock
    input wire logic clk_i,
    input wire logic ce_i,
    // Data
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule // rcu_sync

// ### design/rcu_trim_loader.sv
// Trimming data loader that reads flash words into latches during warm-up
`timescale 1ns/1ps
module rcu_trim_loader
    import rcu_pkg::*;
#(
    parameter int WORDS = TRIM_WORDS
) (
    // Clock and control
    input wire logic clk_i,
    input wire logic ce_i,
    input wire logic clear_i,
    input wire logic start_i,
    // Flash read port
    output logic [7:0] addr_o,
    input wire logic [8:0] data_i,
    // Result
    output logic [8*WORDS-1:0] trim_o,
    output logic done_o,
    output logic bad_o
);
    logic [7:0] idx_r;

    // Each flash word carries odd parity in bit 8; a failing word marks the load abnormal
    always_ff @(posedge clk_i) begin
        if (clear_i) begin
            idx_r <= 8'h00;
            done_o <= 1'b0;
            bad_o <= 1'b0;
            trim_o <= '0;
        end else if (ce_i && start_i && !done_o) begin
            trim_o[idx_r[3:0]*8 +: 8] <= data_i[7:0];
            if (!(^data_i)) begin
                bad_o <= 1'b1;
            end
            if (idx_r == 8'(WORDS - 1)) begin
                done_o <= 1'b1;
            end else begin
                idx_r <= idx_r + 8'h01;
            end
        end
    end

    assign addr_o = idx_r;
endmodule // rcu_trim_loader

// ### dv/rcu_props.sv
// Checker with port-level properties of the reset control unit
`timescale 1ns/1ps
module rcu_props
    import rcu_pkg::*;
#(
    parameter int WARMUP = WARMUP_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [11:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic ack_o,
    // Chip side
    input wire rcu_pkg::chip_ctrl_t ctrl_o,
    input wire rcu_pkg::commit_t commit_o,
    input wire logic [15:0] pc_o,
    input wire logic [15:0] sp_o,
    input wire logic [15:0] code_addr_i,
    input wire logic ram_hit_o,
    input wire logic [15:0] vcall_base_o,
    input wire logic [15:0] ivec_base_o
);
    logic key_w;
    logic [15:0] wcnt_r;
    // =====
    // Helpers
    assign key_w = cyc_i && stb_i && we_i && !ack_o && ce_i && adr_i == OFF_KEY && sel_i[0];
    // Counts warm-up length so that a restart shows as a short count
    always_ff @(posedge clk_i) begin
        if (rst_i || !ctrl_o.warmup_active) wcnt_r <= 16'h0;
        else wcnt_r <= wcnt_r + 16'h1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // =====
    // Properties
    a_ack_next: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o ##1 !ack_o)
        else $error("ack missing or too long");
    a_pc_sp_hold: assert property (pc_o == PC_RESET && sp_o == SP_RESET)
        else $error("pc or sp off reset value");
    a_ram_window: assert property ($stable(code_addr_i) && $stable(commit_o) |-> ram_hit_o ==
        (commit_o.ram_code_map_state && code_addr_i >= RAM_MAP_LO && code_addr_i <= RAM_MAP_HI))
        else $error("ram window wrong");
    a_vec_tables: assert property ($stable(commit_o) |-> vcall_base_o == (commit_o.vector_relocate_state ?
        VCALL_BASE_1 : VCALL_BASE_0) && ivec_base_o == (commit_o.vector_relocate_state ? IVEC_BASE_1 : IVEC_BASE_0))
        else $error("vector table base wrong");
    a_map_by_key: assert property ($rose(commit_o.ram_code_map_state) || $rose(commit_o.vector_relocate_state)
        |-> $past(key_w && dat_i[7:0] == KEY_MAP))
        else $error("map state rose without key");
    a_dis_by_key: assert property ($rose(commit_o.ext_reset_disable_state)
        |-> $past(key_w && dat_i[7:0] == KEY_RSTDIS))
        else $error("disable rose without key");
    a_commit_clear: assert property ($changed(commit_o[2:1]) && !$past(key_w) |-> commit_o[2:1] == 2'b00)
        else $error("map state changed without key");
    a_reset_ctrl: assert property (ctrl_o.sys_reset || ctrl_o.warmup_active |-> ctrl_o.hf_osc_en &&
        !ctrl_o.lf_osc_en && !ctrl_o.watchdog_en && ctrl_o.port_hiz)
        else $error("chip controls wrong in reset");
    a_wdt_after: assert property ($fell(ctrl_o.warmup_active) && !ctrl_o.sys_reset |-> ctrl_o.watchdog_en)
        else $error("watchdog not on after warm-up");
    a_warm_min: assert property ($fell(ctrl_o.warmup_active) && !ctrl_o.sys_reset |-> wcnt_r >= WARMUP - 1)
        else $error("warm-up too short");
    a_warm_stops: assert property (wcnt_r <= WARMUP + 100)
        else $error("warm-up never ends");
    c_map_key: cover property (key_w && dat_i[7:0] == KEY_MAP);
    c_warm_end: cover property ($fell(ctrl_o.warmup_active));
    c_dis_rise: cover property ($rose(commit_o.ext_reset_disable_state));
endmodule // rcu_props

bind reset_control_unit rcu_props #(.WARMUP(WARMUP)) rcu_props_i (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i,
    .we_i, .adr_i, .sel_i, .dat_i, .ack_o, .ctrl_o, .commit_o, .pc_o, .sp_o, .code_addr_i, .ram_hit_o,
    .vcall_base_o, .ivec_base_o);

// ### dv/trim_flash_model.sv
// Flash model that serves trimming words with odd parity
`timescale 1ns/1ps
module trim_flash_model (
    // Read port
    input wire logic [7:0] addr_i,
    input wire logic bad_i,
    output logic [8:0] data_o
);
    logic [7:0] word;
    assign word = addr_i * 8'h3b + 8'h15;
    // Combinational read suits any loader latency; bad_i breaks word 1
    assign data_o = {~^word ^ (bad_i && addr_i == 8'h01), word};
endmodule // trim_flash_model

// ### dv/reset_control_unit_test.sv
// Self-checking testbench of the reset control unit
`timescale 1ns/1ps
module reset_control_unit_test;
    import rcu_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, por_i = 0, ext_lvl = 1, drv = 0, bad = 0;
    logic [11:0] adr_i = 12'h0;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic [15:0] code_addr_i = 16'h0, vcall_base_o, ivec_base_o;
    logic [8:0] trim_data_i;
    logic [7:0] trim_addr_o, codes [4] = '{8'h5a, 8'hb2, 8'hd4, 8'h71};
    logic ack_o, pin_oe_o, lvd_disable_o, ram_hit_o, ext_pin_i;
    int_reset_t int_rst_i = 6'h00;
    chip_ctrl_t ctrl_o;
    commit_t commit_o;
    int miscompares = 0, check_count = 0, st = 0, cm = 0, cf = 0, fc = 0;
    // Open-drain pin with pull-up: low when either side drives it
    assign ext_pin_i = ext_lvl & ~pin_oe_o;
    initial forever #2.5 clk_i = ~clk_i;
    reset_control_unit #(.WARMUP(16)) reset_control_unit_i (.clk_i, .rst_i, .ce_i(1'b1), .cyc_i, .stb_i,
        .we_i, .adr_i, .sel_i(4'h1), .dat_i, .dat_o, .ack_o, .por_i, .ext_pin_i, .int_rst_i,
        .pin_drive_low_i(drv), .pin_o(), .pin_oe_o, .pin_port_o(), .trim_addr_o, .trim_data_i,
        .trim_latch_o(), .ctrl_o, .commit_o, .lvd_disable_o, .pc_o(), .sp_o(), .code_addr_i, .ram_hit_o,
        .vcall_base_o, .ivec_base_o);
    trim_flash_model trim_flash_model_i (.addr_i(trim_addr_o), .bad_i(bad), .data_o(trim_data_i));
    // =====
    // Tasks
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 40);
        r = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        chk("ack", n < 40, 1);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
        if (a == OFF_STAGE) st = d & 7;
        if (a == OFF_CAUSE) fc = d >> 7;
        if (a == OFF_KEY && d == KEY_RSTDIS) cm = (cm & 6) | (st & 1);
        if (a == OFF_KEY && d == KEY_MAP) cm = (cm & 1) | (st & 6);
        if (a == OFF_KEY && d == KEY_FCLR && fc == 1) {cf, fc} = 0;
    endtask
    task automatic rd(input string n, input logic [11:0] a, input int e);
        logic [31:0] r;
        wb(1'b0, a, 8'h00, r);
        chk(n, r, e);
    endtask
    task automatic wait_run();
        int n;
        n = 0;
        repeat (4) @(posedge clk_i);
        while ((ctrl_o.sys_reset !== 1'b0 || ctrl_o.warmup_active !== 1'b0) && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        chk("ready", n < 300, 1);
        {st, cm} = {32'h0, cm & 1};
    endtask
    task automatic pulse(input int i);
        repeat (2) begin
            @(posedge clk_i);
            int_rst_i <= 6'(1 << i);
            repeat (4) @(posedge clk_i);
            int_rst_i <= 6'h00;
            repeat (10) @(posedge clk_i);
        end
        wait_run();
        cf = cf | (i == 5 ? 64 : 1 << i) | (bad ? 32 : 0);
    endtask
    task automatic stop_test();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk_i);
        miscompares++;
        stop_test();
    end
    // =====
    // Tests
    initial begin
        void'($urandom(32'hf245));
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        chk("ctrl_rst", ctrl_o, 8'hab);
        chk("lvd_rst", lvd_disable_o, 1);
        @(posedge clk_i);
        rst_i <= 1'b0;
        wait_run();
        chk("lvd_run", lvd_disable_o, 0);
        rd("cause", OFF_CAUSE, 0);
        rd("stage", OFF_STAGE, 0);
        rd("status", OFF_KEY, 0);
        wr(12'h100, 8'hff);
        rd("unmapped", 12'h100, 0);
        $display("test regs done");
        for (int k = 0; k < 8; k++) begin
            wr(OFF_STAGE, 8'($urandom));
            rd("stage", OFF_STAGE, st);
            rd("staged", OFF_KEY, cm);
            wr(OFF_KEY, codes[k % 4]);
            rd("commit", OFF_KEY, cm);
            foreach (codes[j]) begin
                code_addr_i <= j[0] ? (j[1] ? 16'h083f : 16'h0840) : (j[1] ? 16'h003f : 16'h0040);
                repeat (2) @(posedge clk_i);
                @(negedge clk_i);
                chk("ram_hit", ram_hit_o, cm[1] && code_addr_i >= 16'h0040 && code_addr_i <= 16'h083f);
                chk("vcall", vcall_base_o, cm[2] ? 16'h01a0 : 16'hffa0);
                chk("ivec", ivec_base_o, cm[2] ? 16'h01c2 : 16'hffc2);
            end
        end
        $display("test commit done");
        for (int i = 0; i < 6; i++) begin
            bad = (i == 5);
            pulse(i);
            rd("cause", OFF_CAUSE, cf);
            rd("stage_clr", OFF_STAGE, 0);
            rd("status_kept", OFF_KEY, cm);
        end
        bad = 0;
        wr(OFF_KEY, KEY_FCLR);
        rd("no_clear", OFF_CAUSE, cf);
        wr(OFF_CAUSE, 8'h80);
        wr(OFF_KEY, KEY_FCLR);
        rd("cleared", OFF_CAUSE, 0);
        $display("test cause done");
        wr(OFF_STAGE, 8'h00);
        wr(OFF_KEY, KEY_RSTDIS);
        pulse(0);
        @(posedge clk_i);
        ext_lvl <= 1'b0;
        repeat (4) @(posedge clk_i);
        ext_lvl <= 1'b1;
        wait_run();
        {cf, fc} = 0;
        rd("ext_cause", OFF_CAUSE, 0);
        wr(OFF_STAGE, 8'h01);
        wr(OFF_KEY, KEY_RSTDIS);
        rd("dis_on", OFF_KEY, cm);
        drv <= 1'b1;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        chk("pin_oe", pin_oe_o, 1);
        drv <= 1'b0;
        ext_lvl <= 1'b0;
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
        chk("pin_io", ctrl_o.sys_reset, 0);
        por_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        por_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        chk("or_hold", ctrl_o.sys_reset, 1);
        ext_lvl <= 1'b1;
        wait_run();
        cm = 0;
        rd("por_status", OFF_KEY, 0);
        $display("test pin done");
        stop_test();
    end
endmodule // reset_control_unit_test
